// ### core/fftx_frame_tx.sv
/*
  Fiber frame transmitter: packs words into data, sync and epoch-end frames,
  relays the receiver stream in copy and append modes, and reports status.
  Assumes received words arrive decoded on the same clock and that the line
  side encodes each byte 8b/10b, with control flags marking control characters.
*/
// Overview of operation
// - Line words are 32-bit values, each 40 bits.
// - Data frame carries one to 512 available words.
// - Data frame: pad, start, data, CRC, ends, flow.
// - Sync frame: pad, start, CRC, mark end, status.
// - Epoch end: sync-valid, start, last word, ends.
// - Epoch is data frames then one epoch end.
// - Optional sync frame before data begins.
// - Start embeds user bits; status embeds flags.
// - CRC word enabled or omitted by setting.
// - FIFO overflow outside off mode sets the overflow flag.
// - Flow control obeys stop and go sets.
// - Five modes: off, copy, raw, generate, append.
// - Off mode: transmitter disabled, collection continues.
// - Off with fiber port: FIFO fills, collection stops.
// - Copy mode relays received stream unchanged.
// - Reset leaves copy mode selected.
// - Fiber port in copy mode is invalid.
// - Raw sends converter samples from trigger onward.
// - Raw keeps filtered data on other ports.
// - Low rate in raw needs external clock.
// - Epoch size in bytes is multiple of four.
// - Generate without flow: send at once, ignore input.
// - Generate with flow: wait go and block.
// - Append: relay until sync, epoch, then sync.
module fftx_frame_tx #(
  parameter int ADDR_W = 10,
  parameter int EPOCH_W = 16
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic modeWr,
  input wire fftx_pkg::fftx_mode_type modeIn,
  input wire logic dataPortFiber,
  input wire logic flowCtrlEn,
  input wire logic crcEn,
  input wire logic syncFrameEn,
  input wire logic rateHigh,
  input wire logic extSampleClk,
  input wire logic [EPOCH_W-1:0] epochBytes,
  input wire logic userCtrlBitA,
  input wire logic userCtrlBitB,
  input wire logic dirBit,
  input wire logic notReadyFlag,
  input wire logic ovClear,
  input wire logic trigger,
  input wire logic [31:0] filtWord,
  input wire logic filtValid,
  input wire logic [31:0] rawWord,
  input wire logic rawValid,
  input wire logic [31:0] rxWord,
  input wire logic [3:0] rxCtrl,
  input wire logic rxValid,
  input wire logic txReady,
  output logic [31:0] txWord,
  output logic [3:0] txCtrl,
  output logic txValid,
  output logic txEnable,
  output logic txOverflowFlag,
  output logic configInvalid,
  output logic collectStop,
  output logic filtToBus,
  output fftx_pkg::fftx_mode_type fiberMode
);
  localparam int CW = ADDR_W + 1;
  localparam int EW = EPOCH_W - 2;
  localparam logic [CW-1:0] DEPTH = CW'(2 ** ADDR_W);
  localparam logic [CW-1:0] STOP_LEVEL = CW'(2 ** ADDR_W - fftx_pkg::FRAME_MAX);
  localparam logic [EPOCH_W-1:0] MAX_X = EPOCH_W'(fftx_pkg::FRAME_MAX);

  // Ordered set: control char, type, embedded info, zero pad
  function automatic logic [31:0] osWord(input logic [7:0] kind, input logic [7:0] info);
    return {8'h00, info, kind, fftx_pkg::K_COMMA};
  endfunction

  // One 32-bit step of the frame CRC
  function automatic logic [31:0] crcStep(input logic [31:0] crc, input logic [31:0] word);
    logic [31:0] c;
    c = crc;
    for (int i = 31; i >= 0; i--) begin
      c = (c[31] ^ word[i]) ? ((c << 1) ^ fftx_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  fftx_pkg::fftx_mode_type next_fiberMode;
  fftx_pkg::fftx_state_type state, next_state;
  fftx_pkg::fftx_kind_type kind, next_kind;
  logic modeChg, rxOs, syncEnd, appStart, relayMode, relayLost;
  logic [7:0] rxType;
  logic stopped, next_stopped, rxSdv, next_rxSdv, dropTail, next_dropTail;
  logic [1:0] rxCnt, next_rxCnt;
  logic [2:0][31:0] pw, next_pw;
  logic [2:0][3:0] pc, next_pc;
  logic [2:0] pv, next_pv;
  logic [ADDR_W-1:0] wrPtr, next_wrPtr, rdPtr, next_rdPtr;
  logic [CW-1:0] count, next_count;
  logic [31:0] rdData, wrData, crc, next_crc, next_txWord;
  logic wrReq, wrEn, full, pop, rawGo, next_rawGo, next_ovf;
  logic [3:0] next_txCtrl;
  logic next_txValid, syncPend, next_syncPend, appTurn, next_appTurn, turnData, next_turnData;
  logic [fftx_pkg::LEN_W-1:0] len, next_len;
  logic [EW-1:0] wordsLeft, next_wordsLeft, epochWords, wl;
  logic [EPOCH_W-1:0] countX, roomX, takeX;
  logic epochBad, srcOn, flowOk, blockOk, canData;
  logic next_cfgInv, next_collectStop, next_filtToBus, next_txEnable;

  // Mode register, copy after reset
  always_comb begin
    next_fiberMode = modeWr ? modeIn : fiberMode;
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      fiberMode <= fftx_pkg::MODE_RST;
    end else begin
      fiberMode <= next_fiberMode;
    end
  end
  assign modeChg = modeWr && modeIn != fiberMode;

  // Received stream: ordered-set decode and sync frame detection
  assign rxOs = rxValid && rxCtrl[0] && rxWord[7:0] == fftx_pkg::K_COMMA;
  assign rxType = rxOs ? rxWord[15:8] : 8'h00;
  assign syncEnd = rxType == fftx_pkg::OS_MEND && !rxSdv && rxCnt <= {1'h0, crcEn};
  assign relayMode = fiberMode == fftx_pkg::FM_COPY || fiberMode == fftx_pkg::FM_APPEND;
  assign appStart = fiberMode == fftx_pkg::FM_APPEND && syncEnd && !appTurn;
  assign relayLost = (pv[2] && !txReady && state == fftx_pkg::S_IDLE)
                   || (rxValid && relayMode && appTurn && !dropTail && rxType != fftx_pkg::OS_IDLE);

  // Relay pipeline and flow state
  always_comb begin
    next_stopped = stopped;
    if (rxType == fftx_pkg::OS_STOP) begin
      next_stopped = 1'h1;
    end else if (rxType == fftx_pkg::OS_GO) begin
      next_stopped = 1'h0;
    end
    next_rxCnt = rxCnt;
    if (rxType == fftx_pkg::OS_SOF) begin
      next_rxCnt = 2'h0;
    end else if (rxValid && !rxOs && rxCnt != 2'h3) begin
      next_rxCnt = rxCnt + 2'h1;
    end
    next_rxSdv = rxType == fftx_pkg::OS_SDV ? 1'h1 : (rxType == fftx_pkg::OS_MEND ? 1'h0 : rxSdv);
    next_dropTail = dropTail;
    if (dropTail && (rxType == fftx_pkg::OS_GO || rxType == fftx_pkg::OS_STOP)) begin
      next_dropTail = 1'h0;
    end
    next_pw = {pw[1:0], rxWord};
    next_pc = {pc[1:0], rxCtrl};
    next_pv = {pv[1:0], rxValid && relayMode && !appTurn && !dropTail && !appStart};
    if (appStart) begin
      next_pv = 3'h0; // Squash the arriving sync frame
      next_dropTail = 1'h1;
    end
    if (modeChg) begin
      next_pv = 3'h0;
      next_dropTail = 1'h0;
    end
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stopped <= fftx_pkg::STOPPED_RST;
      rxCnt <= 2'h0;
      rxSdv <= 1'h0;
      dropTail <= 1'h0;
      pw <= '0;
      pc <= '0;
      pv <= 3'h0;
    end else begin
      stopped <= next_stopped;
      rxCnt <= next_rxCnt;
      rxSdv <= next_rxSdv;
      dropTail <= next_dropTail;
      pw <= next_pw;
      pc <= next_pc;
      pv <= next_pv;
    end
  end

  // Transmit FIFO: source select, pointers, overflow
  always_comb begin
    wrReq = (fiberMode == fftx_pkg::FM_RAW) ? (rawGo && rawValid)
          : (filtValid && (fiberMode == fftx_pkg::FM_GEN || fiberMode == fftx_pkg::FM_APPEND
             || (fiberMode == fftx_pkg::FM_OFF && dataPortFiber)));
    wrData = (fiberMode == fftx_pkg::FM_RAW) ? rawWord : filtWord;
    full = count == DEPTH;
    wrEn = wrReq && !full;
    pop = state == fftx_pkg::S_DATA && txReady && !modeChg && fiberMode != fftx_pkg::FM_OFF;
    next_wrPtr = modeChg ? '0 : wrPtr + ADDR_W'(wrEn);
    next_rdPtr = modeChg ? '0 : rdPtr + ADDR_W'(pop);
    next_count = modeChg ? '0 : count + CW'(wrEn) - CW'(pop);
    next_rawGo = modeChg ? 1'h0 : (rawGo || (fiberMode == fftx_pkg::FM_RAW && trigger));
    next_ovf = txOverflowFlag && !ovClear;
    if ((wrReq && full && fiberMode != fftx_pkg::FM_OFF) || relayLost) begin
      next_ovf = 1'h1;
    end
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      rawGo <= 1'h0;
      txOverflowFlag <= 1'h0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
      rawGo <= next_rawGo;
      txOverflowFlag <= next_ovf;
    end
  end

  fftx_word_mem #(.WIDTH(fftx_pkg::WORD_W), .ADDR_W(ADDR_W)) u_mem (
    .clock(clock),
    .wrEn(wrEn),
    .wrAddr(wrPtr),
    .wrData(wrData),
    .rdAddr(next_rdPtr),
    .rdData(rdData)
  );

  // Frame start conditions
  assign epochWords = epochBytes[EPOCH_W-1:2];
  assign epochBad = epochBytes[1:0] != 2'h0 || epochWords == '0;
  assign wl = (wordsLeft == '0) ? epochWords : wordsLeft;
  assign countX = EPOCH_W'(count);
  assign roomX = {2'h0, wl} - EPOCH_W'(1);
  assign takeX = (countX < roomX) ? countX : roomX;
  assign srcOn = !epochBad && (fiberMode == fftx_pkg::FM_RAW || fiberMode == fftx_pkg::FM_GEN
               || (fiberMode == fftx_pkg::FM_APPEND && appTurn));
  assign flowOk = !flowCtrlEn || !stopped;
  assign blockOk = (fiberMode == fftx_pkg::FM_APPEND) ? turnData
                 : (!flowCtrlEn || wordsLeft != '0 || countX >= {2'h0, epochWords});
  assign canData = count != '0 && blockOk;

  // Frame sequencer and line output
  always_comb begin
    next_state = state;
    next_kind = kind;
    next_len = len;
    next_crc = crc;
    next_wordsLeft = wordsLeft;
    next_syncPend = syncPend;
    next_appTurn = appTurn;
    next_turnData = turnData;
    next_txWord = txWord;
    next_txCtrl = txCtrl;
    next_txValid = txValid;
    if (modeChg || fiberMode == fftx_pkg::FM_OFF) begin
      next_state = fftx_pkg::S_IDLE;
      next_txValid = 1'h0;
      next_wordsLeft = '0;
      next_appTurn = 1'h0;
      next_syncPend = modeChg && syncFrameEn
                    && (modeIn == fftx_pkg::FM_RAW || modeIn == fftx_pkg::FM_GEN);
    end else if (txReady) begin
      next_txValid = 1'h1;
      next_txCtrl = fftx_pkg::OS_CTRL;
      case (state)
        fftx_pkg::S_IDLE: begin
          next_txValid = pv[2];
          next_txWord = pw[2];
          next_txCtrl = pc[2];
          if (srcOn && flowOk && syncPend) begin
            next_kind = fftx_pkg::FK_SYNC;
            next_len = '0;
            next_state = fftx_pkg::S_LEAD;
          end else if (srcOn && flowOk && canData) begin
            next_kind = (wl == EW'(1)) ? fftx_pkg::FK_EOE : fftx_pkg::FK_DATA;
            next_len = (wl == EW'(1)) ? fftx_pkg::LEN_W'(1)
                     : fftx_pkg::LEN_W'((takeX > MAX_X) ? MAX_X : takeX);
            next_state = fftx_pkg::S_LEAD;
          end
        end
        fftx_pkg::S_LEAD: begin
          next_txWord = osWord((kind == fftx_pkg::FK_EOE) ? fftx_pkg::OS_SDV : fftx_pkg::OS_IDLE, 8'h00);
          next_crc = fftx_pkg::CRC_INIT;
          next_state = fftx_pkg::S_SOF;
        end
        fftx_pkg::S_SOF: begin
          next_txWord = osWord(fftx_pkg::OS_SOF, 8'h00);
          next_txWord[fftx_pkg::SOF_A_POS] = userCtrlBitA;
          next_txWord[fftx_pkg::SOF_B_POS] = userCtrlBitB;
          next_txWord[fftx_pkg::SOF_DIR_POS] = dirBit;
          next_state = (len != '0) ? fftx_pkg::S_DATA : (crcEn ? fftx_pkg::S_CRC : fftx_pkg::S_END);
        end
        fftx_pkg::S_DATA: begin
          next_txWord = rdData;
          next_txCtrl = fftx_pkg::DATA_CTRL;
          next_crc = crcStep(crc, rdData);
          next_len = len - fftx_pkg::LEN_W'(1);
          next_wordsLeft = wl - EW'(1);
          if (len == fftx_pkg::LEN_W'(1)) begin
            next_state = crcEn ? fftx_pkg::S_CRC : fftx_pkg::S_END;
          end
        end
        fftx_pkg::S_CRC: begin
          next_txWord = crc;
          next_txCtrl = fftx_pkg::DATA_CTRL;
          next_state = fftx_pkg::S_END;
        end
        fftx_pkg::S_END: begin
          next_txWord = osWord((kind == fftx_pkg::FK_DATA) ? fftx_pkg::OS_FEND : fftx_pkg::OS_MEND, 8'h00);
          next_state = fftx_pkg::S_STAT;
        end
        fftx_pkg::S_STAT: begin
          next_txWord = osWord(fftx_pkg::OS_STAT, 8'h00);
          next_txWord[fftx_pkg::STAT_OV_POS] = txOverflowFlag;
          next_txWord[fftx_pkg::STAT_NOT_READY_FLAG_POS] = notReadyFlag;
          next_state = fftx_pkg::S_FLOW;
        end
        fftx_pkg::S_FLOW: begin
          next_txWord = osWord((count >= STOP_LEVEL) ? fftx_pkg::OS_STOP : fftx_pkg::OS_GO, 8'h00);
          next_state = fftx_pkg::S_IDLE;
          if (kind == fftx_pkg::FK_SYNC) begin
            next_syncPend = 1'h0;
            next_appTurn = 1'h0;
          end else if (kind == fftx_pkg::FK_EOE && fiberMode == fftx_pkg::FM_APPEND) begin
            next_syncPend = 1'h1;
            next_turnData = 1'h0;
          end
        end
        default: begin
          next_state = fftx_pkg::S_IDLE;
          next_txValid = 1'h0;
        end
      endcase
    end
    if (appStart) begin
      next_appTurn = 1'h1;
      next_turnData = count != '0 && countX >= {2'h0, epochWords};
      next_syncPend = !(count != '0 && countX >= {2'h0, epochWords});
    end
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= fftx_pkg::S_IDLE;
      kind <= fftx_pkg::FK_DATA;
      len <= '0;
      crc <= fftx_pkg::CRC_INIT;
      wordsLeft <= '0;
      syncPend <= 1'h0;
      appTurn <= 1'h0;
      turnData <= 1'h0;
      txWord <= '0;
      txCtrl <= 4'h0;
      txValid <= 1'h0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      len <= next_len;
      crc <= next_crc;
      wordsLeft <= next_wordsLeft;
      syncPend <= next_syncPend;
      appTurn <= next_appTurn;
      turnData <= next_turnData;
      txWord <= next_txWord;
      txCtrl <= next_txCtrl;
      txValid <= next_txValid;
    end
  end

  // Configuration checks and data routing status
  always_comb begin
    next_cfgInv = (dataPortFiber && (fiberMode == fftx_pkg::FM_COPY || fiberMode == fftx_pkg::FM_RAW))
                || (epochBad && fiberMode != fftx_pkg::FM_OFF && fiberMode != fftx_pkg::FM_COPY)
                || (fiberMode == fftx_pkg::FM_RAW && !rateHigh && !extSampleClk);
    next_collectStop = fiberMode == fftx_pkg::FM_OFF && dataPortFiber && full;
    next_filtToBus = (fiberMode == fftx_pkg::FM_OFF && !dataPortFiber) || fiberMode == fftx_pkg::FM_COPY
                   || fiberMode == fftx_pkg::FM_RAW;
    next_txEnable = fiberMode != fftx_pkg::FM_OFF;
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      configInvalid <= 1'h0;
      collectStop <= 1'h0;
      filtToBus <= 1'h1;
      txEnable <= 1'h1;
    end else begin
      configInvalid <= next_cfgInv;
      collectStop <= next_collectStop;
      filtToBus <= next_filtToBus;
      txEnable <= next_txEnable;
    end
  end

  // Checks
  a_mode_reset: assert property (@(posedge clock) $fell(sys_rst) |-> fiberMode == fftx_pkg::FM_COPY)
    else $error("mode not copy after reset");
  a_off_silent: assert property (@(posedge clock) disable iff (sys_rst)
    fiberMode == fftx_pkg::FM_OFF |=> !txValid && !txEnable) else $error("off mode transmits");
  a_sof_embeds: assert property (@(posedge clock) disable iff (sys_rst)
    state == fftx_pkg::S_SOF && txReady && !modeChg && fiberMode != fftx_pkg::FM_OFF
    |=> txCtrl == fftx_pkg::OS_CTRL && txWord[15:8] == fftx_pkg::OS_SOF && txWord[16] == $past(userCtrlBitA))
    else $error("start set wrong");
  a_eoe_lead: assert property (@(posedge clock) disable iff (sys_rst)
    state == fftx_pkg::S_SOF && kind == fftx_pkg::FK_EOE |-> txWord[15:8] == fftx_pkg::OS_SDV && len == 10'h001)
    else $error("epoch end frame malformed");
  a_len_max: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(state == fftx_pkg::S_LEAD) |-> len <= 10'h200) else $error("frame too long");
  a_crc_opt: assert property (@(posedge clock) disable iff (sys_rst)
    state == fftx_pkg::S_CRC |-> crcEn) else $error("CRC sent while disabled");
  a_ovf_sticky: assert property (@(posedge clock) disable iff (sys_rst)
    txOverflowFlag && !ovClear |=> txOverflowFlag) else $error("overflow flag lost");
  a_copy_relay: assert property (@(posedge clock) disable iff (sys_rst)
    fiberMode == fftx_pkg::FM_COPY && $past(fiberMode, 4) == fftx_pkg::FM_COPY && !$past(modeWr)
    && $past(rxValid, 4) && $past(txReady) |-> txValid && txWord == $past(rxWord, 4))
    else $error("copy relay mismatch");
  a_copy_invalid: assert property (@(posedge clock) disable iff (sys_rst)
    fiberMode == fftx_pkg::FM_COPY && dataPortFiber |=> configInvalid) else $error("invalid state missed");
  a_gen_routing: assert property (@(posedge clock) disable iff (sys_rst)
    fiberMode == fftx_pkg::FM_GEN |=> !filtToBus) else $error("generate leaks to bus");
  a_stop_holds: assert property (@(posedge clock) disable iff (sys_rst)
    flowCtrlEn && stopped && state == fftx_pkg::S_IDLE |=> state == fftx_pkg::S_IDLE)
    else $error("frame started while stopped");
  c_eoe_sent: cover property (@(posedge clock) state == fftx_pkg::S_FLOW && kind == fftx_pkg::FK_EOE);
  c_sync_sent: cover property (@(posedge clock) state == fftx_pkg::S_FLOW && kind == fftx_pkg::FK_SYNC);
  c_append_turn: cover property (@(posedge clock) disable iff (sys_rst) appStart);
  c_overflow: cover property (@(posedge clock) disable iff (sys_rst) $rose(txOverflowFlag));
endmodule

// ### core/fftx_pkg.sv
/*
  Shared constants and types of the fiber frame transmitter: ordered-set
  codes, embedded bit positions, CRC settings, modes, states and reset values.
  Assumes a downstream 8b/10b serializer that turns each control-flagged byte
  into a control character.
*/
package fftx_pkg;
  localparam int WORD_W = 32;
  localparam int FRAME_MAX = 512;
  localparam int LEN_W = 10;
  // Control character in byte 0 of every ordered set
  localparam logic [7:0] K_COMMA = 8'hbc;
  localparam logic [3:0] OS_CTRL = 4'h1;
  localparam logic [3:0] DATA_CTRL = 4'h0;
  // Ordered-set type codes, byte 1
  localparam logic [7:0] OS_IDLE = 8'h01;
  localparam logic [7:0] OS_SOF = 8'h02;
  localparam logic [7:0] OS_FEND = 8'h03;
  localparam logic [7:0] OS_MEND = 8'h04;
  localparam logic [7:0] OS_STAT = 8'h05;
  localparam logic [7:0] OS_GO = 8'h06;
  localparam logic [7:0] OS_STOP = 8'h07;
  localparam logic [7:0] OS_SDV = 8'h08;
  // Embedded bits, byte 2 of start and status sets
  localparam int SOF_A_POS = 16;
  localparam int SOF_B_POS = 17;
  localparam int SOF_DIR_POS = 18;
  localparam int STAT_OV_POS = 16;
  localparam int STAT_NOT_READY_FLAG_POS = 17;
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  typedef enum logic [2:0] {
    FM_OFF = 3'h0,
    FM_COPY = 3'h1,
    FM_RAW = 3'h2,
    FM_GEN = 3'h3,
    FM_APPEND = 3'h4
  } fftx_mode_type;
  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_LEAD = 8'h02,
    S_SOF = 8'h04,
    S_DATA = 8'h08,
    S_CRC = 8'h10,
    S_END = 8'h20,
    S_STAT = 8'h40,
    S_FLOW = 8'h80
  } fftx_state_type;
  typedef enum logic [1:0] {
    FK_DATA = 2'h0,
    FK_SYNC = 2'h1,
    FK_EOE = 2'h2
  } fftx_kind_type;
  localparam fftx_mode_type MODE_RST = FM_COPY;
  localparam logic STOPPED_RST = 1'h1;
endpackage

// ### core/fftx_word_mem.sv
/*
  Word store of the transmit FIFO: one write port, one read port with
  registered read data and write-through on an address match.
  Assumes the caller keeps the pointers and the fill count.
*/
module fftx_word_mem #(
  parameter int WIDTH = 32,
  parameter int ADDR_W = 10
) (
  input wire logic clock,
  input wire logic wrEn,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] store [2**ADDR_W];

  // Write, and read with bypass of a same-cycle write
  always_ff @(posedge clock) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
    rdData <= (wrEn && wrAddr == rdAddr) ? wrData : store[rdAddr];
  end
endmodule

// ### tb/fftx_far_end.sv
/*
  Far-end model: downstream receiver that feeds the relay input and paces
  the line. Assumes one clock shared with the transmitter.
*/
module fftx_far_end (
  input wire logic clock,
  input wire logic slow,
  output logic txReady,
  output logic [31:0] rxWord,
  output logic [3:0] rxCtrl,
  output logic rxValid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    txReady = 1'h1;
    rxWord = 32'h0;
    rxCtrl = 4'h0;
    rxValid = 1'h0;
  end
  // Pacing: prompt, or ready every other cycle
  always @(negedge clock) txReady <= slow ? ~txReady : 1'h1;
  // One 32-bit value per cycle, per-byte control flags
  task automatic send(input logic [31:0] w, input logic [3:0] c);
    rxWord = w;
    rxCtrl = c;
    rxValid = 1'h1;
    @(negedge clock);
  endtask
  // Released line shows no stale value
  task automatic quiet();
    rxValid = 1'h0;
    rxWord = ~rxWord;
    rxCtrl = ~rxCtrl;
  endtask
endmodule

// ### tb/tb_top.sv
/*
  Self-checking bench of the frame transmitter: relay, frame layout,
  status outputs and modes. Assumes the far-end model file is compiled first.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'h0, sys_rst = 1'h1, modeWr = 1'h0, dataPortFiber = 1'h0, slow = 1'h0;
  logic flowCtrlEn = 1'h0, crcEn = 1'h0, syncFrameEn = 1'h0, rateHigh = 1'h0, extSampleClk = 1'h0;
  logic userCtrlBitA = 1'h1, userCtrlBitB = 1'h0, dirBit = 1'h1, notReadyFlag = 1'h1;
  logic ovClear = 1'h0, trigger = 1'h0, filtValid = 1'h0, rawValid = 1'h0;
  logic [15:0] epochBytes = 16'h0008;
  logic [31:0] filtWord = 32'h0, rawWord = 32'h0, rxWord, txWord, w0, w1;
  logic [31:0] lfsr = 32'hde0b;
  logic [3:0] rxCtrl, txCtrl;
  logic rxValid, txReady, txValid, txEnable, txOverflowFlag, configInvalid, collectStop, filtToBus;
  fftx_pkg::fftx_mode_type modeIn = fftx_pkg::FM_COPY, fiberMode;
  logic [35:0] expQ[$];
  int nErrors = 0, totalChecks = 0, cycles = 0;
  fftx_far_end far (.clock(clock), .slow(slow), .txReady(txReady), .rxWord(rxWord),
    .rxCtrl(rxCtrl), .rxValid(rxValid));
  fftx_frame_tx #(.ADDR_W(10), .EPOCH_W(16)) uut (.clock(clock), .sys_rst(sys_rst),
    .modeWr(modeWr), .modeIn(modeIn), .dataPortFiber(dataPortFiber), .flowCtrlEn(flowCtrlEn),
    .crcEn(crcEn), .syncFrameEn(syncFrameEn), .rateHigh(rateHigh), .extSampleClk(extSampleClk),
    .epochBytes(epochBytes), .userCtrlBitA(userCtrlBitA), .userCtrlBitB(userCtrlBitB),
    .dirBit(dirBit), .notReadyFlag(notReadyFlag), .ovClear(ovClear), .trigger(trigger),
    .filtWord(filtWord), .filtValid(filtValid), .rawWord(rawWord), .rawValid(rawValid),
    .rxWord(rxWord), .rxCtrl(rxCtrl), .rxValid(rxValid), .txReady(txReady), .txWord(txWord),
    .txCtrl(txCtrl), .txValid(txValid), .txEnable(txEnable), .txOverflowFlag(txOverflowFlag),
    .configInvalid(configInvalid), .collectStop(collectStop), .filtToBus(filtToBus),
    .fiberMode(fiberMode));
  always #10 clock = ~clock;
  task automatic complete_run();
    if (nErrors == 0 && totalChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [35:0] e, input logic [35:0] g);
    totalChecks++;
    if (g !== e) begin
      nErrors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  // Step the pseudo-random source
  function automatic void rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
  endfunction
  // Ordered set as line word with its control flag
  function automatic logic [35:0] os(input logic [7:0] info, input logic [7:0] kind);
    return {4'h1, 8'h00, info, kind, 8'hbc};
  endfunction
  // Frame check word of one data word from the preset value
  function automatic logic [35:0] crcOf(input logic [31:0] w);
    logic [31:0] c;
    c = fftx_pkg::CRC_INIT;
    for (int i = 31; i >= 0; i--) begin
      c = (c[31] ^ w[i]) ? ((c << 1) ^ fftx_pkg::CRC_POLY) : (c << 1);
    end
    return {4'h0, c};
  endfunction
  task automatic setMode(input fftx_pkg::fftx_mode_type m);
    modeWr = 1'h1;
    modeIn = m;
    @(negedge clock);
    modeWr = 1'h0;
    repeat (2) @(negedge clock);
    chk("fiberMode", {33'h0, m}, {33'h0, fiberMode});
  endtask
  // Line monitor takes the oldest note per accepted word
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      nErrors++;
      complete_run();
    end
    if (!sys_rst && txValid === 1'h1 && txReady === 1'h1) begin
      if (expQ.size() == 0) chk("spare word", 'x, {txCtrl, txWord});
      else chk("line word", expQ.pop_front(), {txCtrl, txWord});
    end
  end
  initial begin
    repeat (12) @(negedge clock);
    sys_rst = 1'h0;
    repeat (2) @(negedge clock);
    chk("fiberMode", {33'h0, fftx_pkg::FM_COPY}, {33'h0, fiberMode});
    chk("txEnable", 36'h1, {35'h0, txEnable});
    // Relay of back-to-back received words
    repeat (3) begin
      rnd();
      expQ.push_back({4'h0, lfsr});
      far.send(lfsr, 4'h0);
    end
    far.quiet();
    repeat (8) @(negedge clock);
    chk("relay left", 36'h0, 36'(expQ.size()));
    // Slow line: one of two equal relay words is lost
    slow = 1'h1;
    expQ.push_back({4'h0, lfsr});
    repeat (2) far.send(lfsr, 4'h0);
    far.quiet();
    repeat (8) @(negedge clock);
    chk("txOverflowFlag", 36'h1, {35'h0, txOverflowFlag});
    ovClear = 1'h1;
    @(negedge clock);
    ovClear = 1'h0;
    chk("txOverflowFlag", 36'h0, {35'h0, txOverflowFlag});
    // Generate with CRC and flow control: data frame then epoch end
    setMode(fftx_pkg::FM_GEN);
    chk("filtToBus", 36'h0, {35'h0, filtToBus});
    crcEn = 1'h1;
    flowCtrlEn = 1'h1;
    rnd();
    w0 = lfsr;
    rnd();
    w1 = lfsr;
    expQ.push_back(os(8'h00, fftx_pkg::OS_IDLE));
    expQ.push_back(os(8'h05, fftx_pkg::OS_SOF));
    expQ.push_back({4'h0, w0});
    expQ.push_back(crcOf(w0));
    expQ.push_back(os(8'h00, fftx_pkg::OS_FEND));
    expQ.push_back(os(8'h02, fftx_pkg::OS_STAT));
    expQ.push_back(os(8'h00, fftx_pkg::OS_GO));
    expQ.push_back(os(8'h00, fftx_pkg::OS_SDV));
    expQ.push_back(os(8'h05, fftx_pkg::OS_SOF));
    expQ.push_back({4'h0, w1});
    expQ.push_back(crcOf(w1));
    expQ.push_back(os(8'h00, fftx_pkg::OS_MEND));
    expQ.push_back(os(8'h02, fftx_pkg::OS_STAT));
    expQ.push_back(os(8'h00, fftx_pkg::OS_GO));
    filtWord = w0;
    filtValid = 1'h1;
    @(negedge clock);
    filtWord = w1;
    @(negedge clock);
    filtValid = 1'h0;
    repeat (6) @(negedge clock);
    chk("held while stopped", 36'he, 36'(expQ.size()));
    far.send({16'h0000, fftx_pkg::OS_GO, 8'hbc}, 4'h1);
    far.quiet();
    for (int i = 0; i < 80 && expQ.size() > 0; i++) @(negedge clock);
    chk("frames left", 36'h0, 36'(expQ.size()));
    slow = 1'h0;
    flowCtrlEn = 1'h0;
    // Raw at the low rate needs an external sample clock
    setMode(fftx_pkg::FM_RAW);
    chk("configInvalid", 36'h1, {35'h0, configInvalid});
    rateHigh = 1'h1;
    repeat (2) @(negedge clock);
    chk("configInvalid", 36'h0, {35'h0, configInvalid});
    setMode(fftx_pkg::FM_APPEND);
    setMode(fftx_pkg::FM_OFF);
    chk("txEnable", 36'h0, {35'h0, txEnable});
    // Off with fiber port: fill the store until collection stops
    dataPortFiber = 1'h1;
    filtValid = 1'h1;
    repeat (1030) begin
      rnd();
      filtWord = lfsr;
      @(negedge clock);
    end
    filtValid = 1'h0;
    @(negedge clock);
    chk("collectStop", 36'h1, {35'h0, collectStop});
    setMode(fftx_pkg::FM_COPY);
    @(negedge clock);
    chk("configInvalid", 36'h1, {35'h0, configInvalid});
    complete_run();
  end
endmodule
